// *** frps_pkg.sv ***
package frps_pkg;
	// Command codes of the registers on the management port
	localparam logic [7:0] CMD_VIN_UV_RESP = 8'h5A;
	localparam logic [7:0] CMD_PG_ON = 8'h5E;
	localparam logic [7:0] CMD_PG_OFF = 8'h5F;
	localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
	localparam logic [7:0] CMD_TURN_ON_RISE_TIME = 8'h61;
	localparam logic [7:0] CMD_FAULT_UNIT = 8'hD2;
	localparam logic [7:0] CMD_MULTI_PIN = 8'hF9;
	localparam logic [7:0] CMD_STATUS = 8'h79;
	// Fault response byte fields
	localparam int RESP_MODE_HI = 7;
	localparam int RESP_MODE_LO = 6;
	localparam int RESP_RETRY_HI = 5;
	localparam int RESP_RETRY_LO = 3;
	localparam int RESP_DLY_HI = 2;
	localparam int RESP_DLY_LO = 0;
	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_DELAYED = 2'h1;
	localparam logic [1:0] MODE_RETRY = 2'h2;
	localparam logic [1:0] MODE_LATCH = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	// Multi-pin configuration: power good pin enable bit
	localparam int MPC_PG_EN_BIT = 0;
	// Status word bits
	localparam int STAT_PG_BIT = 11;
	localparam int STAT_OFF_BIT = 6;
	localparam int STAT_UV_BIT = 3;
	// Reset values
	localparam logic [7:0] RESP_RESET = 8'hBA;
	localparam logic [15:0] PG_ON_RESET = 16'h0000;
	localparam logic [15:0] PG_OFF_RESET = 16'h0000;
	localparam logic [15:0] TURN_ON_DELAY_TIME_RESET = 16'h0005;
	localparam logic [15:0] TURN_ON_RISE_TIME_RESET = 16'h000A;
	localparam logic [15:0] FAULT_UNIT_RESET = 16'h0001;
	localparam logic [7:0] MULTI_PIN_RESET = 8'h01;
	// Timing: one millisecond at 50 MHz
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
endpackage : frps_pkg

// *** frps_tick.sv ***
`timescale 1ns/1ns
module frps_tick #(
	parameter int DIV = 50000
) (
	input wire logic CLK,
	input wire logic RESETN,
	output logic TICK
);
	logic [31:0] cnt_reg;
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt_reg <= 32'h0;
			TICK <= 1'b0;
		end else if (cnt_reg == 32'(DIV - 1)) begin
			cnt_reg <= 32'h0;
			TICK <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
			TICK <= 1'b0;
		end
	end
endmodule : frps_tick

// *** frps_timer.sv ***
`timescale 1ns/1ns
// Down-counter of enable pulses; DONE is a one-cycle pulse at expiry
module frps_timer (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic START,
	input wire logic [23:0] LOAD,
	input wire logic TICK,
	output logic DONE,
	output logic BUSY
);
	logic [23:0] cnt_reg;
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt_reg <= 24'h0;
			BUSY <= 1'b0;
			DONE <= 1'b0;
		end else if (START) begin
			cnt_reg <= LOAD;
			BUSY <= 1'b1;
			DONE <= 1'b0;
		end else if (BUSY && (cnt_reg == 24'h0)) begin
			BUSY <= 1'b0;
			DONE <= 1'b1;
		end else begin
			DONE <= 1'b0;
			if (BUSY && TICK) begin
				cnt_reg <= cnt_reg - 24'h1;
			end
		end
	end
endmodule : frps_timer

// *** frps_sequencer.sv ***
// Behaviour
// [R01] Retry codes 2..6 give that many restarts
// [R02] All restarts failed: output off until cleared
// [R03] Restart spacing is delay count times unit
// [R04] Retry code 7 retries without limit
// [R05] Endless retry stops on off or other fault
// [R06] Delay field decodes to two to the value
// [R07] Delay count is ride-through or restart spacing
// [R08] Fault time unit comes from separate register
// [R09] Power good asserts at on threshold
// [R10] Pin negates below off threshold if enabled
// [R11] Below off threshold sets status power-good bit
// [R12] Wait turn-on delay in ms after enable
// [R13] Ramp output over rise time in ms
// [R14] Host uses word reads and writes
// [R15] Mode 01 rides through, then applies retries; the code stops in ST_WAIT with no timer started if retries are left
// [R16] Mode 10 disables output, then retries
// [R17] Retry code 0 never restarts
// [R18] Attempt counter clears on clear or off
// [R19] Fault before ramp end fails attempt; in mode 01 the code stays in ST_RISE instead
`timescale 1ns/1ns
module frps_sequencer #(
	parameter int MS_DIV = frps_pkg::CYC_PER_MS
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic ENABLE,
	input wire logic OTHER_FAULT,
	input wire logic UV_FAULT,
	input wire logic CLEAR_FAULTS,
	input wire logic [15:0] VOUT,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] CMD,
	input wire logic [15:0] WDATA,
	output logic [15:0] RDATA,
	output logic OUT_ON,
	output logic RAMPING,
	output logic [15:0] VOUT_TARGET_FRAC,
	output logic POWER_GOOD_PIN,
	output logic FAULT_LATCHED
);
	typedef enum logic [5:0] {
		ST_OFF = 6'b000001,
		ST_DELAY = 6'b000010,
		ST_RISE = 6'b000100,
		ST_ON = 6'b001000,
		ST_WAIT = 6'b010000,
		ST_LATCH = 6'b100000
	} frps_state_e;

	frps_state_e state_reg;
	logic [7:0] resp_reg;
	logic [15:0] pg_on_reg;
	logic [15:0] pg_off_reg;
	logic [15:0] turn_on_delay_time_reg;
	logic [15:0] turn_on_rise_time_reg;
	logic [15:0] unit_reg;
	logic [7:0] mpc_reg;
	logic [2:0] tries_reg;
	logic ride_reg;
	logic pg_stat_reg;
	logic [1:0] mode;
	logic [2:0] retry;
	logic ms_tick;
	logic unit_tick;
	logic [15:0] unit_cnt_reg;
	logic t_start;
	logic [23:0] t_load;
	logic t_done;
	logic t_busy;
	logic [15:0] rise_el_reg;
	logic can_retry;

	// [R06] Delay decode as power of two
	function automatic logic [23:0] dly_units(input logic [7:0] r);
		dly_units = 24'h1 << r[frps_pkg::RESP_DLY_HI:frps_pkg::RESP_DLY_LO];
	endfunction : dly_units

	assign mode = resp_reg[frps_pkg::RESP_MODE_HI:frps_pkg::RESP_MODE_LO];
	assign retry = resp_reg[frps_pkg::RESP_RETRY_HI:frps_pkg::RESP_RETRY_LO];
	// [R01] [R04] [R17] Attempt budget check
	assign can_retry = (retry == frps_pkg::RETRY_FOREVER) || (tries_reg < retry);

	frps_tick #(.DIV(MS_DIV)) u_ms (
		.CLK(CLK),
		.RESETN(RESETN),
		.TICK(ms_tick)
	);

	// [R08] Fault time unit counted in ms from own register
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			unit_cnt_reg <= 16'h0;
			unit_tick <= 1'b0;
		end else begin
			unit_tick <= 1'b0;
			if (ms_tick) begin
				if (unit_cnt_reg + 16'h1 >= unit_reg) begin
					unit_cnt_reg <= 16'h0;
					unit_tick <= 1'b1;
				end else begin
					unit_cnt_reg <= unit_cnt_reg + 16'h1;
				end
			end
		end
	end

	logic timer_tick;
	assign timer_tick = (state_reg == ST_DELAY || state_reg == ST_RISE) ? ms_tick : unit_tick;

	frps_timer u_tmr (
		.CLK(CLK),
		.RESETN(RESETN),
		.START(t_start),
		.LOAD(t_load),
		.TICK(timer_tick),
		.DONE(t_done),
		.BUSY(t_busy)
	);

	// Register writes; host uses word transfers
	// [R14] Word write decode
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			resp_reg <= frps_pkg::RESP_RESET;
			pg_on_reg <= frps_pkg::PG_ON_RESET;
			pg_off_reg <= frps_pkg::PG_OFF_RESET;
			turn_on_delay_time_reg <= frps_pkg::TURN_ON_DELAY_TIME_RESET;
			turn_on_rise_time_reg <= frps_pkg::TURN_ON_RISE_TIME_RESET;
			unit_reg <= frps_pkg::FAULT_UNIT_RESET;
			mpc_reg <= frps_pkg::MULTI_PIN_RESET;
		end else if (WR_EN) begin
			unique case (CMD)
				frps_pkg::CMD_VIN_UV_RESP: resp_reg <= WDATA[7:0];
				frps_pkg::CMD_PG_ON: pg_on_reg <= WDATA;
				frps_pkg::CMD_PG_OFF: pg_off_reg <= WDATA;
				frps_pkg::CMD_TURN_ON_DELAY_TIME: turn_on_delay_time_reg <= WDATA;
				frps_pkg::CMD_TURN_ON_RISE_TIME: turn_on_rise_time_reg <= WDATA;
				frps_pkg::CMD_FAULT_UNIT: unit_reg <= WDATA;
				frps_pkg::CMD_MULTI_PIN: mpc_reg <= WDATA[7:0];
				default: ;
			endcase
		end
	end

	// Read data registered; unknown codes read zero
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			RDATA <= 16'h0;
		end else if (RD_EN) begin
			unique case (CMD)
				frps_pkg::CMD_VIN_UV_RESP: RDATA <= {8'h0, resp_reg};
				frps_pkg::CMD_PG_ON: RDATA <= pg_on_reg;
				frps_pkg::CMD_PG_OFF: RDATA <= pg_off_reg;
				frps_pkg::CMD_TURN_ON_DELAY_TIME: RDATA <= turn_on_delay_time_reg;
				frps_pkg::CMD_TURN_ON_RISE_TIME: RDATA <= turn_on_rise_time_reg;
				frps_pkg::CMD_FAULT_UNIT: RDATA <= unit_reg;
				frps_pkg::CMD_MULTI_PIN: RDATA <= {8'h0, mpc_reg};
				frps_pkg::CMD_STATUS: RDATA <= (16'(pg_stat_reg) << frps_pkg::STAT_PG_BIT)
					| (16'(!OUT_ON) << frps_pkg::STAT_OFF_BIT)
					| (16'(UV_FAULT) << frps_pkg::STAT_UV_BIT);
				default: RDATA <= 16'h0;
			endcase
		end
	end

	// Sequencer; timer start is combinational on the same edge as state change
	always_comb begin
		t_start = 1'b0;
		t_load = 24'h0;
		unique case (state_reg)
			ST_OFF: begin
				t_start = ENABLE && !OTHER_FAULT;
				t_load = {8'h0, turn_on_delay_time_reg};
			end
			ST_DELAY: begin
				t_start = t_done;
				t_load = {8'h0, turn_on_rise_time_reg};
			end
			ST_ON: begin
				t_start = UV_FAULT && !ride_reg && mode == frps_pkg::MODE_DELAYED;
				t_load = dly_units(resp_reg);
			end
			ST_RISE: begin
				t_start = UV_FAULT && mode == frps_pkg::MODE_RETRY && can_retry;
				t_load = dly_units(resp_reg);
			end
			// [R03] Wait expiry starts the turn-on delay on the same edge
			ST_WAIT: begin
				t_start = t_done;
				t_load = {8'h0, turn_on_delay_time_reg};
			end
			default: ;
		endcase
		if (state_reg == ST_ON && UV_FAULT && mode == frps_pkg::MODE_RETRY && can_retry) begin
			t_start = 1'b1;
			t_load = dly_units(resp_reg);
		end
	end

	logic uv_act;
	assign uv_act = UV_FAULT && mode != frps_pkg::MODE_IGNORE;

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state_reg <= ST_OFF;
			ride_reg <= 1'b0;
		end else if (!ENABLE || OTHER_FAULT) begin
			// [R05] Off command or other fault ends retrying
			state_reg <= ST_OFF;
			ride_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_OFF: state_reg <= ST_DELAY;
				// [R12] Turn-on delay
				ST_DELAY: if (t_done) state_reg <= ST_RISE;
				// [R13] [R19] Ramp; fault before ramp end fails attempt in modes 10 and 11, mode 01 stays in ST_RISE
				ST_RISE: begin
					if (uv_act) begin
						if (mode == frps_pkg::MODE_RETRY && can_retry) state_reg <= ST_WAIT;
						else if (mode != frps_pkg::MODE_DELAYED) state_reg <= ST_LATCH;
					end else if (t_done) state_reg <= ST_ON;
				end
				ST_ON: begin
					// [R15] Ride-through, then ST_LATCH, or ST_WAIT with no wait timer started if retries are left
					if (mode == frps_pkg::MODE_DELAYED) begin
						if (UV_FAULT && !ride_reg) ride_reg <= 1'b1;
						else if (!UV_FAULT) ride_reg <= 1'b0;
						else if (t_done) begin
							ride_reg <= 1'b0;
							state_reg <= ST_LATCH;
							if (can_retry) state_reg <= ST_WAIT;
						end
					// [R16] [R17] Disable then retry if allowed
					end else if (uv_act) begin
						if (mode == frps_pkg::MODE_RETRY && can_retry) state_reg <= ST_WAIT;
						else state_reg <= ST_LATCH;
					end
				end
				// [R03] [R07] Wait spacing then restart
				ST_WAIT: if (t_done) state_reg <= ST_DELAY;
				// [R02] Stay off until cleared
				ST_LATCH: if (CLEAR_FAULTS) state_reg <= ST_OFF;
				default: state_reg <= ST_OFF;
			endcase
		end
	end

	// Restart from wait reloads delay timer
	logic restart_go;
	assign restart_go = state_reg == ST_WAIT && t_done;

	// [R18] Attempt counter cleared on clear or off
	always_ff @(posedge CLK) begin
		if (!RESETN || !ENABLE || CLEAR_FAULTS || state_reg == ST_OFF) begin
			tries_reg <= 3'h0;
		end else if (restart_go && retry != frps_pkg::RETRY_FOREVER) begin
			tries_reg <= tries_reg + 3'h1;
		end
	end

	// Ramp progress for the analog reference, in ms elapsed
	always_ff @(posedge CLK) begin
		if (!RESETN || state_reg != ST_RISE) rise_el_reg <= 16'h0;
		else if (ms_tick && rise_el_reg != turn_on_rise_time_reg) rise_el_reg <= rise_el_reg + 16'h1;
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			OUT_ON <= 1'b0;
			RAMPING <= 1'b0;
			VOUT_TARGET_FRAC <= 16'h0;
			FAULT_LATCHED <= 1'b0;
		end else begin
			// Off command drops the output on the next edge, not one later
			OUT_ON <= ENABLE && !OTHER_FAULT && (state_reg == ST_RISE || state_reg == ST_ON);
			RAMPING <= ENABLE && !OTHER_FAULT && state_reg == ST_RISE;
			VOUT_TARGET_FRAC <= (state_reg == ST_ON) ? turn_on_rise_time_reg : rise_el_reg;
			FAULT_LATCHED <= state_reg == ST_LATCH;
		end
	end

	// [R09] [R10] [R11] Power good hysteresis and status
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			POWER_GOOD_PIN <= 1'b0;
			pg_stat_reg <= 1'b1;
		end else if (!(state_reg == ST_ON || state_reg == ST_RISE)) begin
			POWER_GOOD_PIN <= 1'b0;
			pg_stat_reg <= 1'b1;
		end else if (VOUT >= pg_on_reg) begin
			POWER_GOOD_PIN <= mpc_reg[frps_pkg::MPC_PG_EN_BIT];
			pg_stat_reg <= 1'b0;
		end else if (VOUT < pg_off_reg) begin
			pg_stat_reg <= 1'b1;
			if (mpc_reg[frps_pkg::MPC_PG_EN_BIT]) POWER_GOOD_PIN <= 1'b0;
		end
	end
endmodule : frps_sequencer

// *** frps_chk.sv ***
`timescale 1ns/1ns
module frps_chk (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic ENABLE,
	input wire logic OTHER_FAULT,
	input wire logic CLEAR_FAULTS,
	input wire logic RD_EN,
	input wire logic [15:0] RDATA,
	input wire logic OUT_ON,
	input wire logic RAMPING,
	input wire logic [15:0] VOUT_TARGET_FRAC,
	input wire logic FAULT_LATCHED
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_latch_off: assert property (
		FAULT_LATCHED |-> !OUT_ON) else $error("on while latched");
	a_latch_hold: assert property (
		FAULT_LATCHED && ENABLE && !CLEAR_FAULTS |=> FAULT_LATCHED) else $error("latch lost");
	a_disable_off: assert property (
		!ENABLE |=> !OUT_ON) else $error("on while disabled");
	a_other_fault_off: assert property (
		OTHER_FAULT [*2] |=> !OUT_ON) else $error("on during other fault");
	a_ramp_in_on: assert property (
		RAMPING |-> OUT_ON) else $error("ramp while off");
	// Ramp progress moves up one millisecond step at a time
	a_ramp_steps: assert property (
		RAMPING && $past(RAMPING) |-> VOUT_TARGET_FRAC >= $past(VOUT_TARGET_FRAC)
		&& VOUT_TARGET_FRAC <= $past(VOUT_TARGET_FRAC) + 16'h0001) else $error("ramp jump");
	a_start_ramp: assert property (
		$rose(OUT_ON) |-> RAMPING) else $error("on without ramp");
	a_delay_first: assert property (
		$rose(OUT_ON) |-> $past(ENABLE, 8)) else $error("turn-on too early");
	a_rdata_hold: assert property (
		!RD_EN |=> $stable(RDATA)) else $error("read data moved");
	cover property ($rose(RAMPING));
	cover property ($rose(FAULT_LATCHED));
	cover property (OTHER_FAULT && !OUT_ON);
endmodule : frps_chk

bind frps_sequencer frps_chk i_chk (.CLK, .RESETN, .ENABLE, .OTHER_FAULT, .CLEAR_FAULTS,
	.RD_EN, .RDATA, .OUT_ON, .RAMPING, .VOUT_TARGET_FRAC, .FAULT_LATCHED);

// *** frps_host.sv ***
`timescale 1ns/1ns
module frps_host (
	input wire logic CLK,
	input wire logic [15:0] RDATA,
	output logic WR_EN,
	output logic RD_EN,
	output logic [7:0] CMD,
	output logic [15:0] WDATA
);
	initial begin
		WR_EN = 1'b0;
		RD_EN = 1'b0;
		CMD = 8'h00;
		WDATA = 16'h0000;
	end
	// Released lines show the inverse so a stale value never passes
	task automatic rel();
		@(posedge CLK) #2;
		WR_EN = 1'b0;
		RD_EN = 1'b0;
		CMD = ~CMD;
		WDATA = ~WDATA;
	endtask : rel
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge CLK) #2;
		CMD = c;
		WDATA = d;
		WR_EN = 1'b1;
		rel();
	endtask : wr
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge CLK) #2;
		CMD = c;
		RD_EN = 1'b1;
		rel();
		d = RDATA;
	endtask : rd
endmodule : frps_host

// *** tb_fault_retry_power_sequencer.sv ***
`timescale 1ns/1ns
module tb_fault_retry_power_sequencer;
	localparam int MSD = 10;
	typedef struct {logic [7:0] c; logic w; logic [15:0] d; logic [15:0] e;} frps_row_s;
	logic CLK = 1'b0, RESETN = 1'b0, ENABLE = 1'b0, OTHER_FAULT = 1'b0;
	logic UV_FAULT = 1'b0, CLEAR_FAULTS = 1'b0, on_d = 1'b0;
	logic WR_EN, RD_EN, OUT_ON, RAMPING, POWER_GOOD_PIN, FAULT_LATCHED;
	logic [7:0] CMD;
	logic [15:0] VOUT = 16'h0000, WDATA, RDATA, VOUT_TARGET_FRAC, v;
	int failures = 0, n_tests = 0, cyc = 0, rises = 0, gap = 0, last = 0, t0;
	frps_row_s rows [14] = '{'{8'h5E, 0, 16'h0, 16'h0000}, '{8'h5F, 0, 16'h0, 16'h0000},
		'{8'h60, 0, 16'h0, 16'h0005}, '{8'h61, 0, 16'h0, 16'h000A}, '{8'h5A, 0, 16'h0, 16'h00BA},
		'{8'hD2, 0, 16'h0, 16'h0001}, '{8'hF9, 0, 16'h0, 16'h0001}, '{8'h33, 1, 16'hBEEF, 16'h0},
		'{8'h5E, 1, 16'h0100, 16'h0100}, '{8'h5F, 1, 16'h0080, 16'h0080},
		'{8'h60, 1, 16'h0002, 16'h0002}, '{8'h61, 1, 16'h0003, 16'h0003},
		'{8'h5A, 1, 16'h12A5, 16'h00A5}, '{8'hD2, 1, 16'h0001, 16'h0001}};
	always #10 CLK = ~CLK;
	frps_sequencer #(.MS_DIV(MSD)) i_dut (.CLK, .RESETN, .ENABLE, .OTHER_FAULT, .UV_FAULT,
		.CLEAR_FAULTS, .VOUT, .WR_EN, .RD_EN, .CMD, .WDATA, .RDATA, .OUT_ON, .RAMPING,
		.VOUT_TARGET_FRAC, .POWER_GOOD_PIN, .FAULT_LATCHED);
	frps_host i_host (.CLK, .RDATA, .WR_EN, .RD_EN, .CMD, .WDATA);
	always @(posedge CLK) begin
		cyc++;
		if (OUT_ON === 1'b1 && !on_d) begin
			rises++;
			gap = cyc - last;
			last = cyc;
		end
		on_d = (OUT_ON === 1'b1);
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rng(input string n, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			failures++;
			$display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask : rng
	task automatic tk(input int n);
		repeat (n) @(posedge CLK);
		#2;
	endtask : tk
	// Bounded wait; a hang shows up as a later mismatch, not a stall
	task automatic wt(ref logic s, input logic val, input int n);
		for (int k = 0; k < n && s !== val; k++) tk(1);
	endtask : wt
	task automatic up();
		ENABLE = 1'b1;
		wt(RAMPING, 1'b1, 300);
		wt(RAMPING, 1'b0, 300);
	endtask : up
	task automatic clr();
		UV_FAULT = 1'b0;
		CLEAR_FAULTS = 1'b1;
		tk(1);
		CLEAR_FAULTS = 1'b0;
		ENABLE = 1'b0;
		tk(5);
		chk("latch cleared", 16'h0000, 16'(FAULT_LATCHED));
	endtask : clr
	task automatic flt(input logic [1:0] m, input logic [2:0] n, input logic [2:0] d,
		input logic [15:0] u);
		int e;
		e = ((1 << d) * u + 2) * MSD;
		i_host.wr(8'h5A, {8'h00, m, n, d});
		i_host.wr(8'hD2, u);
		up();
		UV_FAULT = 1'b1;
		rises = 0;
		wt(FAULT_LATCHED, 1'b1, 3000);
		chk("restarts", 16'((m == 2'h3) ? 3'h0 : n), 16'(rises));
		if (n > 1) rng("restart gap", e - 22, e + 12, gap);
		tk(100);
		chk("stays off", 16'h0001, 16'({OUT_ON, FAULT_LATCHED}));
		clr();
	endtask : flt
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		tk(12);
		RESETN = 1'b1;
		chk("reset outputs", 16'h0000, VOUT_TARGET_FRAC | 16'({OUT_ON, RAMPING, FAULT_LATCHED}));
		i_host.rd(8'h79, v);
		chk("status pg at reset", 16'h0001, 16'(v[11]));
		foreach (rows[i]) begin
			if (rows[i].w) i_host.wr(rows[i].c, rows[i].d);
			i_host.rd(rows[i].c, v);
			chk("register", rows[i].e, v);
		end
		ENABLE = 1'b1;
		t0 = cyc;
		wt(OUT_ON, 1'b1, 200);
		rng("delay cycles", 11, 24, cyc - t0);
		t0 = cyc;
		wt(RAMPING, 1'b0, 200);
		rng("rise cycles", 20, 34, cyc - t0);
		chk("ramp end", 16'h0003, VOUT_TARGET_FRAC);
		VOUT = 16'h0100;
		tk(3);
		chk("pg on", 16'h0001, 16'(POWER_GOOD_PIN));
		VOUT = 16'h0080;
		tk(3);
		chk("pg hold", 16'h0001, 16'(POWER_GOOD_PIN));
		VOUT = 16'h007F;
		tk(3);
		chk("pg off", 16'h0000, 16'(POWER_GOOD_PIN));
		i_host.rd(8'h79, v);
		chk("status pg", 16'h0001, 16'(v[11]));
		ENABLE = 1'b0;
		tk(2);
		i_host.wr(8'h5A, 16'h0041);
		up();
		UV_FAULT = 1'b1;
		tk(8);
		chk("ride through", 16'h0001, 16'(OUT_ON));
		wt(FAULT_LATCHED, 1'b1, 60);
		chk("ride end", 16'h0001, 16'({OUT_ON, FAULT_LATCHED}));
		clr();
		flt(2'h2, 3'h0, 3'h0, 16'h0001);
		flt(2'h3, 3'h0, 3'h0, 16'h0001);
		flt(2'h2, 3'h1, 3'h0, 16'h0001);
		flt(2'h2, 3'h2, 3'h0, 16'h0001);
		flt(2'h2, 3'h3, 3'h2, 16'h0001);
		flt(2'h2, 3'h4, 3'h3, 16'h0001);
		flt(2'h2, 3'h5, 3'h1, 16'h0002);
		flt(2'h2, 3'h6, 3'h0, 16'h0001);
		i_host.wr(8'h5A, 16'h00B8);
		up();
		UV_FAULT = 1'b1;
		rises = 0;
		tk(400);
		chk("endless", 16'h0000, 16'(FAULT_LATCHED));
		rng("endless rises", 8, 50, rises);
		OTHER_FAULT = 1'b1;
		tk(5);
		t0 = rises;
		tk(200);
		chk("other fault stop", 16'h0000, 16'({OUT_ON, 8'(rises - t0)}));
		OTHER_FAULT = 1'b0;
		clr();
		finish_test();
	end
endmodule : tb_fault_retry_power_sequencer
